// ===== vppr_pkg.sv
// Constants and types for the VBUS port protection register bank
package vppr_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam int NREG = 26;
	localparam logic [7:0] REG_ADDR [NREG] = '{8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1D,
		8'h1E, 8'h1F, 8'h36, 8'h37, 8'h3A, 8'h3C, 8'h3D, 8'h3F, 8'h53, 8'h54, 8'h55, 8'h56, 8'h57, 8'h58,
		8'h59, 8'h5A, 8'h60};
	localparam logic [7:0] REG_RST [NREG] = '{8'h00, 8'h00, 8'h22, 8'h22, 8'h02, 8'h50, 8'h50, 8'h22, 8'h02,
		8'h50, 8'h00, 8'h00, 8'h00, 8'hCF, 8'h00, 8'h00, 8'h81, 8'h0A, 8'h35, 8'h70, 8'h80, 8'h70, 8'h00,
		8'h1B, 8'h00, 8'h00};
	localparam logic [7:0] REG_WMASK [NREG] = '{8'h16, 8'h00, 8'h7F, 8'h7F, 8'h03, 8'hFF, 8'hFF, 8'h7F, 8'h03,
		8'hFF, 8'h01, 8'hFF, 8'hFF, 8'hCF, 8'hFF, 8'h00, 8'hC1, 8'hFF, 8'hFF, 8'hFF, 8'hF3, 8'hFF, 8'h03,
		8'hFF, 8'h03, 8'h80};
	localparam int IX_CEN = 0, IX_CSTS = 1, IX_OC1 = 2, IX_OC2 = 3, IX_OC3 = 4, IX_OC1T = 5, IX_OC2T = 6;
	localparam int IX_RC1 = 7, IX_RC3 = 8, IX_RC1T = 9, IX_VSEL = 10, IX_PATH = 11, IX_OT = 12;
	localparam int IX_SWEN = 13, IX_OVACT = 14, IX_OVSTS = 15, IX_FODD = 16 + 1, IX_FODT = 18;
	localparam int IX_VTH0L = 19, IX_TOL = 20, IX_VTH1L = 21, IX_VTH1H = 22, IX_VTH2L = 23, IX_VTH2H = 24;
	localparam int IX_SNK = 25;
	// Field positions
	localparam int EN_OC2_BIT = 1, EN_RC1_BIT = 2, EN_X3_BIT = 4;
	localparam int STS_OC1 = 0, STS_OC2 = 1, STS_OC3 = 2, STS_RC1 = 4, STS_RC3 = 6;
	localparam int LONG_BIT = 7, CNT_MSB = 6, LVL_MSB = 6;
	localparam int OT_EN_BIT = 0, OT_VC_BIT = 1;
	localparam int DPDM_DEG_BIT = 7, SBU_DEG_BIT = 6, REC_LSB = 4, REC_EDGE_BIT = 3;
	localparam int SNK_TRIG_BIT = 7, T2_LSB = 4, T1_LSB = 0, TOL_LSB = 4, SNK_EN_BIT = 7;
	// Switch kill masks {vconn, sbu2, sbu1, dm, dp}
	localparam logic [4:0] KILL_ALL = 5'h1F;
	localparam logic [4:0] KILL_OWN [3] = '{5'h0C, 5'h03, 5'h10};

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_HZ = 10_000_000;
	localparam int MS_TIME_MS = 1;
	localparam int MS_CYCLES = CLK_HZ / 1000 * MS_TIME_MS;
	localparam int STEP_SHORT_MS = 10, STEP_LONG_MS = 50;
	localparam logic [3:0] TICKS_PER_STEP_MAX = 4'(STEP_SHORT_MS / MS_TIME_MS - 1);
	localparam logic [2:0] LONG_SUB_MAX = 3'(STEP_LONG_MS / STEP_SHORT_MS - 1);
	localparam int REC_STEP_US = 200, REC_BASE_STEPS = 2;
	localparam int REC_STEP_CYCLES = CLK_HZ / 1_000_000 * REC_STEP_US;
	localparam int DEG_TIME_NS = 2000;
	localparam logic [4:0] DEG_CYCLES = 5'((DEG_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000);
	localparam int CTD_BASE_MS = 70, CTD_STEP_MS = 2, FOD_STEP_MS = 2;
	localparam int T1_BASE_MS = 5, T2_BASE_MS = 45, T_STEP_MS = 5;
	localparam int VTH_LSB_MV = 4, TOL_STEP = 2;

	// ****************************************
	// Types
	// ****************************************
	typedef struct packed {logic oc1; logic oc2; logic oc3; logic rc1; logic rc3;} vppr_cur_s;
	typedef struct packed {logic sbu2; logic sbu1; logic dm; logic dp; logic vconn;} vppr_ov_s;
	typedef struct packed {logic sbu2; logic sbu1; logic dm; logic dp;} vppr_sw_s;
	typedef struct packed {
		logic [6:0] oc1; logic [6:0] oc2; logic [1:0] oc3; logic [6:0] rc1; logic [1:0] rc3; logic high_vbus;
	} vppr_lvl_s;
	typedef struct packed {logic [9:0] vth0; logic [9:0] vth1; logic [9:0] vth2;} vppr_vth_s;
	typedef struct packed {logic hit; logic [4:0] idx;} vppr_hit_s;
	typedef enum logic [1:0] {FOD_IDLE, FOD_WAIT1, FOD_WAIT2} vppr_fod_e;

	// Address to register index
	function automatic vppr_hit_s vppr_lookup(input logic [7:0] a);
		vppr_hit_s r;
		r = '0;
		for (int i = 0; i < NREG; i++) begin
			if (REG_ADDR[i] == a) begin
				r.hit = 1'b1;
				r.idx = 5'(i);
			end
		end
		return r;
	endfunction : vppr_lookup

	// Cable-type delay in ms
	function automatic logic [7:0] vppr_ctd_ms(input logic [3:0] code);
		return 8'(CTD_BASE_MS + CTD_STEP_MS * int'(code));
	endfunction : vppr_ctd_ms

	// Sample time in ms from a base and a 3-bit code
	function automatic logic [6:0] vppr_sample_ms(input int base, input logic [2:0] code);
		return 7'(base + T_STEP_MS * int'(code));
	endfunction : vppr_sample_ms
endpackage : vppr_pkg

// ===== vppr_regs.sv
// VBUS port protection register bank and its protection logic
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module vppr_regs
	import vppr_pkg::*;
#(
	parameter int MS_CYC = MS_CYCLES,
	parameter int REC_STEP_CYC = REC_STEP_CYCLES
) (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RSTN,
	// Register port
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	// Current comparators and levels
	input wire logic STD_STANDARD_OVERCURRENT_ENABLE,
	input wire vppr_cur_s CUR_DET,
	output vppr_lvl_s CUR_LEVEL,
	output logic ALERT,
	// Watchdog and temperature
	input wire logic WDT_TIMEOUT,
	output logic [3:0] PATH_RESTORE,
	input wire logic OT_DET,
	output logic OT_PROTECT,
	// Overvoltage and switches
	input wire vppr_ov_s OV_DET,
	output vppr_sw_s SW_ON,
	output logic VCONN_OFF,
	// Foreign-object detection
	output logic [7:0] CTD_DELAY_MS,
	output logic [7:0] FOD_DELAY_MS,
	input wire logic SINK_CONNECTED,
	input wire logic [9:0] ADC_DATA,
	output logic FOD_PULLUP_ON,
	output logic FOD_DONE,
	output logic FOD_NOT_LOWER,
	output vppr_vth_s FOD_VTH
);
	localparam int MS_W = $clog2(MS_CYC + 1);
	localparam int REC_W = $clog2((REC_BASE_STEPS + 4) * REC_STEP_CYC);

	// ****************************************
	// Register port
	// ****************************************
	logic [7:0] regs [NREG];
	vppr_hit_s wr_hit, rd_hit;
	logic [7:0] rd_val, cur_sts, next_cur_sts, ov_flag, next_ov_flag;

	assign wr_hit = vppr_lookup(ADDR);
	assign rd_hit = wr_hit;

	// Masked register writes
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			for (int i = 0; i < NREG; i++) begin
				regs[i] <= REG_RST[i];
			end
		end else if (WR && wr_hit.hit) begin
			regs[wr_hit.idx] <= (regs[wr_hit.idx] & ~REG_WMASK[wr_hit.idx]) | (WDATA & REG_WMASK[wr_hit.idx]);
		end
	end

	// Read value with live and status overlays
	always_comb begin
		rd_val = regs[rd_hit.idx];
		if (!rd_hit.hit) begin
			rd_val = 8'h00;
		end else if (rd_hit.idx == 5'(IX_CEN)) begin
			rd_val = {regs[IX_CEN][7:1], STD_STANDARD_OVERCURRENT_ENABLE};
		end else if (rd_hit.idx == 5'(IX_CSTS)) begin
			rd_val = cur_sts;
		end else if (rd_hit.idx == 5'(IX_OVSTS)) begin
			rd_val = {ov_flag[7:4], SW_ON};
		end
	end

	// Read data one cycle after the strobe
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			RDATA <= 8'h00;
		end else if (RD) begin
			RDATA <= rd_val;
		end
	end

	// Threshold codes to the analog side
	always_comb begin
		CUR_LEVEL.oc1 = regs[IX_OC1][LVL_MSB:0];
		CUR_LEVEL.oc2 = regs[IX_OC2][LVL_MSB:0];
		CUR_LEVEL.oc3 = regs[IX_OC3][1:0];
		CUR_LEVEL.rc1 = regs[IX_RC1][LVL_MSB:0];
		CUR_LEVEL.rc3 = regs[IX_RC3][1:0];
		CUR_LEVEL.high_vbus = regs[IX_VSEL][0];
		FOD_VTH.vth0 = {regs[IX_TOL][1:0], regs[IX_VTH0L]};
		FOD_VTH.vth1 = {regs[IX_VTH1H][1:0], regs[IX_VTH1L]};
		FOD_VTH.vth2 = {regs[IX_VTH2H][1:0], regs[IX_VTH2L]};
	end

	// ****************************************
	// Time base
	// ****************************************
	logic [MS_W-1:0] ms_cnt;
	logic [3:0] deca;
	logic ms_tick, tick10;

	assign ms_tick = (ms_cnt == MS_W'(MS_CYC - 1));
	assign tick10 = ms_tick && (deca == TICKS_PER_STEP_MAX);

	// Millisecond and 10 ms enables
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			ms_cnt <= '0;
			deca <= 4'h0;
		end else begin
			ms_cnt <= ms_tick ? '0 : ms_cnt + 1'b1;
			if (ms_tick) begin
				deca <= tick10 ? 4'h0 : deca + 4'h1;
			end
		end
	end

	// ****************************************
	// Current persistence timers
	// ****************************************
	logic [2:0] ch_det, ch_long, ch_fire, ch_fired;
	logic [6:0] ch_limit [3];
	logic [6:0] ch_steps [3];
	logic [2:0] ch_sub [3];
	logic x3_en;

	// Channel 0 OC1, 1 OC2, 2 RC1
	always_comb begin
		x3_en = regs[IX_CEN][EN_X3_BIT];
		ch_det[0] = CUR_DET.oc1 & STD_STANDARD_OVERCURRENT_ENABLE;
		ch_det[1] = CUR_DET.oc2 & regs[IX_CEN][EN_OC2_BIT];
		ch_det[2] = CUR_DET.rc1 & regs[IX_CEN][EN_RC1_BIT];
		ch_limit[0] = regs[IX_OC1T][CNT_MSB:0];
		ch_limit[1] = regs[IX_OC2T][CNT_MSB:0];
		ch_limit[2] = regs[IX_RC1T][CNT_MSB:0];
		ch_long = {regs[IX_RC1T][LONG_BIT], regs[IX_OC2T][LONG_BIT], regs[IX_OC1T][LONG_BIT]};
		for (int c = 0; c < 3; c++) begin
			ch_fire[c] = ch_det[c] && !ch_fired[c] && (ch_steps[c] >= ch_limit[c]);
		end
	end

	// Step counting while the condition persists
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			ch_fired <= 3'h0;
			for (int c = 0; c < 3; c++) begin
				ch_steps[c] <= 7'h00;
				ch_sub[c] <= 3'h0;
			end
		end else begin
			for (int c = 0; c < 3; c++) begin
				if (!ch_det[c]) begin
					ch_fired[c] <= 1'b0;
					ch_steps[c] <= 7'h00;
					ch_sub[c] <= 3'h0;
				end else if (ch_fire[c]) begin
					ch_fired[c] <= 1'b1;
				end else if (!ch_fired[c] && tick10) begin
					if (ch_sub[c] == (ch_long[c] ? LONG_SUB_MAX : 3'h0)) begin
						ch_sub[c] <= 3'h0;
						ch_steps[c] <= ch_steps[c] + 7'h01;
					end else begin
						ch_sub[c] <= ch_sub[c] + 3'h1;
					end
				end
			end
		end
	end

	// ****************************************
	// Current status and alert
	// ****************************************
	logic [7:0] cur_set, cur_live;
	logic cur_rd, ov_rd;

	assign cur_rd = RD && rd_hit.hit && (rd_hit.idx == 5'(IX_CSTS));
	assign ov_rd = RD && rd_hit.hit && (rd_hit.idx == 5'(IX_OVSTS));

	// Sticky flags, set beats clear-on-read
	always_comb begin
		cur_set = 8'h00;
		cur_live = 8'h00;
		cur_set[STS_OC1] = ch_fire[0];
		cur_set[STS_OC2] = ch_fire[1];
		cur_set[STS_OC3] = CUR_DET.oc3 & x3_en;
		cur_set[STS_RC1] = ch_fire[2];
		cur_set[STS_RC3] = CUR_DET.rc3 & x3_en;
		cur_live[STS_OC1] = ch_det[0];
		cur_live[STS_OC2] = ch_det[1];
		cur_live[STS_OC3] = cur_set[STS_OC3];
		cur_live[STS_RC1] = ch_det[2];
		cur_live[STS_RC3] = cur_set[STS_RC3];
		next_cur_sts = (cur_rd ? (cur_sts & cur_live) : cur_sts) | cur_set;
	end

	// Status register and alert output
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			cur_sts <= 8'h00;
			ALERT <= 1'b0;
		end else begin
			cur_sts <= next_cur_sts;
			ALERT <= |next_cur_sts;
		end
	end

	// ****************************************
	// Watchdog restore and overtemperature
	// ****************************************
	logic ot_vconn;

	// Path restore pulse and temperature actions
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			PATH_RESTORE <= 4'h0;
			OT_PROTECT <= 1'b0;
			ot_vconn <= 1'b0;
		end else begin
			PATH_RESTORE <= WDT_TIMEOUT ? regs[IX_PATH][3:0] : 4'h0;
			OT_PROTECT <= OT_DET & regs[IX_OT][OT_EN_BIT];
			ot_vconn <= OT_DET & regs[IX_OT][OT_EN_BIT] & regs[IX_OT][OT_VC_BIT];
		end
	end

	// ****************************************
	// Overvoltage deglitch and recovery
	// ****************************************
	logic [2:0] grp_raw, grp_deg, grp_q, grp_prev, killed, rec_run;
	logic [4:0] deg_cnt [3];
	logic [REC_W-1:0] rec_cnt [3];
	logic [REC_W-1:0] rec_load;
	logic [4:0] kill;
	logic rec_fall;

	// Groups 0 SBU, 1 DP/DM, 2 VCONN
	always_comb begin
		grp_raw = {OV_DET.vconn, OV_DET.dm | OV_DET.dp, OV_DET.sbu1 | OV_DET.sbu2};
		grp_deg = {1'b0, regs[IX_OVACT][DPDM_DEG_BIT], regs[IX_OVACT][SBU_DEG_BIT]};
		rec_fall = regs[IX_OVACT][REC_EDGE_BIT];
		rec_load = REC_W'((REC_BASE_STEPS + int'(regs[IX_OVACT][REC_LSB+:2])) * REC_STEP_CYC - 1);
		kill = 5'h00;
		for (int g = 0; g < 3; g++) begin
			if (killed[g]) begin
				kill = kill | (regs[IX_OVACT][g] ? KILL_ALL : KILL_OWN[g]);
			end
		end
	end

	// Deglitch filter per group
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			grp_q <= 3'h0;
			for (int g = 0; g < 3; g++) begin
				deg_cnt[g] <= 5'h00;
			end
		end else begin
			for (int g = 0; g < 3; g++) begin
				if (grp_raw[g] == grp_q[g]) begin
					deg_cnt[g] <= 5'h00;
				end else if (!grp_deg[g] || deg_cnt[g] == DEG_CYCLES - 5'h01) begin
					grp_q[g] <= grp_raw[g];
					deg_cnt[g] <= 5'h00;
				end else begin
					deg_cnt[g] <= deg_cnt[g] + 5'h01;
				end
			end
		end
	end

	// Switch-off hold and recovery timing
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			grp_prev <= 3'h0;
			killed <= 3'h0;
			rec_run <= 3'h0;
			for (int g = 0; g < 3; g++) begin
				rec_cnt[g] <= '0;
			end
		end else begin
			grp_prev <= grp_q;
			for (int g = 0; g < 3; g++) begin
				if (grp_q[g] && !grp_prev[g]) begin
					killed[g] <= 1'b1;
					rec_run[g] <= !rec_fall;
					rec_cnt[g] <= rec_load;
				end else if (!grp_q[g] && grp_prev[g] && rec_fall) begin
					rec_run[g] <= 1'b1;
					rec_cnt[g] <= rec_load;
				end else if (rec_run[g]) begin
					if (rec_cnt[g] == '0) begin
						rec_run[g] <= 1'b0;
					end else begin
						rec_cnt[g] <= rec_cnt[g] - 1'b1;
					end
				end else if (killed[g] && !grp_q[g]) begin
					killed[g] <= 1'b0;
				end
			end
		end
	end

	// Next overvoltage flags, set beats clear-on-read
	always_comb begin
		next_ov_flag = 8'h00;
		next_ov_flag[7:4] = (ov_rd ? (ov_flag[7:4] & OV_DET[4:1]) : ov_flag[7:4])
			| (OV_DET[4:1] & {grp_q[0], grp_q[0], grp_q[1], grp_q[1]});
	end

	// Registered switch drive, VCONN cut and flags
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			SW_ON <= '0;
			VCONN_OFF <= 1'b0;
			ov_flag <= 8'h00;
		end else begin
			SW_ON <= regs[IX_SWEN][3:0] & ~kill[3:0];
			VCONN_OFF <= kill[4] | ot_vconn;
			ov_flag <= next_ov_flag;
		end
	end

	// ****************************************
	// Foreign-object detection
	// ****************************************
	vppr_fod_e fod_st;
	logic [6:0] fod_ms;
	logic [9:0] fod_s1;
	logic sink_prev, fod_trig;

	assign fod_trig = regs[IX_FODT][SNK_TRIG_BIT] && !regs[IX_SNK][SNK_EN_BIT] && SINK_CONNECTED && !sink_prev;

	// Delay figures for the cable and FOD timers
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			CTD_DELAY_MS <= 8'h00;
			FOD_DELAY_MS <= 8'h00;
		end else begin
			CTD_DELAY_MS <= vppr_ctd_ms(regs[IX_FODD][7:4]);
			FOD_DELAY_MS <= vppr_ctd_ms(regs[IX_FODD][7:4]) + 8'(FOD_STEP_MS * int'(regs[IX_FODD][3:0]));
		end
	end

	// Pull-up, two samples and comparison
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			fod_st <= FOD_IDLE;
			fod_ms <= 7'h00;
			fod_s1 <= 10'h000;
			sink_prev <= 1'b0;
			FOD_PULLUP_ON <= 1'b0;
			FOD_DONE <= 1'b0;
			FOD_NOT_LOWER <= 1'b0;
		end else begin
			sink_prev <= SINK_CONNECTED;
			FOD_DONE <= 1'b0;
			if (ms_tick) begin
				fod_ms <= fod_ms + 7'h01;
			end
			unique case (fod_st)
				FOD_IDLE: begin
					if (fod_trig) begin
						fod_st <= FOD_WAIT1;
						fod_ms <= 7'h00;
						FOD_PULLUP_ON <= 1'b1;
					end
				end
				FOD_WAIT1: begin
					if (!SINK_CONNECTED) begin
						fod_st <= FOD_IDLE;
						FOD_PULLUP_ON <= 1'b0;
					end else if (fod_ms == vppr_sample_ms(T1_BASE_MS, regs[IX_FODT][T1_LSB+:3])) begin
						fod_s1 <= ADC_DATA;
						fod_st <= FOD_WAIT2;
					end
				end
				FOD_WAIT2: begin
					if (!SINK_CONNECTED) begin
						fod_st <= FOD_IDLE;
						FOD_PULLUP_ON <= 1'b0;
					end else if (fod_ms == vppr_sample_ms(T2_BASE_MS, regs[IX_FODT][T2_LSB+:3])) begin
						FOD_NOT_LOWER <= ({1'b0, ADC_DATA} + 11'(TOL_STEP * (int'(regs[IX_TOL][TOL_LSB+:2]) + 1)))
							>= {1'b0, fod_s1};
						FOD_DONE <= 1'b1;
						FOD_PULLUP_ON <= 1'b0;
						fod_st <= FOD_IDLE;
					end
				end
			endcase
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking a_cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RSTN);

	a_oc2_fire_count: assert property (ch_fire[1] && ch_limit[1] != 7'h00 |-> $past(ch_det[1]))
		else $error("OC2 fired without a persisting condition");
	a_rc1_fire_status: assert property (ch_fire[2] |=> cur_sts[STS_RC1] && ALERT)
		else $error("RC1 event not latched");
	a_oc3_status: assert property (CUR_DET.oc3 && x3_en |=> cur_sts[STS_OC3])
		else $error("OC3 status not set");
	a_flag_sticky: assert property (cur_sts[STS_OC1] && !cur_rd |=> cur_sts[STS_OC1])
		else $error("OC1 status lost without a read");
	a_path_restore: assert property (WDT_TIMEOUT |=> PATH_RESTORE == $past(regs[IX_PATH][3:0]))
		else $error("Path restore does not follow enables");
	a_ot_gate: assert property (OT_PROTECT |-> $past(OT_DET) && $past(regs[IX_OT][OT_EN_BIT]))
		else $error("Overtemperature acted while disabled");
	a_sbu_kill: assert property (killed[0] |=> !SW_ON.sbu1 && !SW_ON.sbu2)
		else $error("SBU switch on during overvoltage hold");
	a_rec_load: assert property ($rose(rec_run[1]) |-> rec_cnt[1] == $past(rec_load))
		else $error("Recovery time not loaded");
	a_ctd_delay: assert property ($past(RSTN) |->
		CTD_DELAY_MS == 8'(CTD_BASE_MS + CTD_STEP_MS * int'($past(regs[IX_FODD][7:4]))))
		else $error("Cable delay wrong");
	a_fod_start: assert property (fod_st == FOD_IDLE && fod_trig |=> FOD_PULLUP_ON ##1 FOD_PULLUP_ON)
		else $error("FOD pull-up not started");
	a_fod_done: assert property (FOD_DONE |-> !FOD_PULLUP_ON && $past(fod_st == FOD_WAIT2))
		else $error("FOD result without second sample");
endmodule : vppr_regs

// ===== vppr_regs_tb.sv
// Self-checking testbench for the VBUS port protection register bank
`timescale 1ns/1ps
module vppr_regs_tb
	import vppr_pkg::*;
;
	// ****************************************
	// Signals
	// ****************************************
	logic SYS_CLK;
	logic RSTN;
	logic WR;
	logic RD;
	logic STD_STANDARD_OVERCURRENT_ENABLE;
	logic WDT_TIMEOUT;
	logic OT_DET;
	logic SINK_CONNECTED;
	logic ALERT;
	logic OT_PROTECT;
	logic VCONN_OFF;
	logic FOD_PULLUP_ON;
	logic FOD_DONE;
	logic FOD_NOT_LOWER;
	logic [7:0] ADDR;
	logic [7:0] WDATA;
	logic [7:0] RDATA;
	logic [7:0] CTD_DELAY_MS;
	logic [7:0] FOD_DELAY_MS;
	logic [9:0] ADC_DATA;
	logic [3:0] PATH_RESTORE;
	vppr_cur_s CUR_DET;
	vppr_lvl_s CUR_LEVEL;
	vppr_ov_s OV_DET;
	vppr_sw_s SW_ON;
	vppr_vth_s FOD_VTH;
	int mismatches = 0;
	int checked = 0;
	int cycles = 0;
	logic [31:0] seed = 32'h0000_005F;
	logic [7:0] wv [NREG];
	// Overvoltage cases: control, pins, length, first wait, switches, vconn off, flags
	logic [7:0] o_ctl [6] = '{8'h00, 8'h38, 8'h02, 8'h00, 8'h40, 8'h40};
	logic [4:0] o_pin [6] = '{5'h08, 5'h02, 5'h04, 5'h01, 5'h10, 5'h10};
	int o_len [6] = '{2, 20, 2, 2, 10, 30};
	int o_w1 [6] = '{13, 45, 3, 3, 3, 1};
	logic [3:0] o_sw [6] = '{4'h3, 4'hC, 4'h0, 4'hF, 4'hF, 4'h3};
	logic o_vc [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
	logic [7:0] o_flg [6] = '{8'h4F, 8'h1F, 8'h2F, 8'h0F, 8'h0F, 8'h8F};

	vppr_regs #(.MS_CYC(20), .REC_STEP_CYC(10)) uut (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .ADDR(ADDR),
		.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .STD_STANDARD_OVERCURRENT_ENABLE(STD_STANDARD_OVERCURRENT_ENABLE), .CUR_DET(CUR_DET),
		.CUR_LEVEL(CUR_LEVEL), .ALERT(ALERT), .WDT_TIMEOUT(WDT_TIMEOUT), .PATH_RESTORE(PATH_RESTORE),
		.OT_DET(OT_DET), .OT_PROTECT(OT_PROTECT), .OV_DET(OV_DET), .SW_ON(SW_ON), .VCONN_OFF(VCONN_OFF),
		.CTD_DELAY_MS(CTD_DELAY_MS), .FOD_DELAY_MS(FOD_DELAY_MS), .SINK_CONNECTED(SINK_CONNECTED),
		.ADC_DATA(ADC_DATA), .FOD_PULLUP_ON(FOD_PULLUP_ON), .FOD_DONE(FOD_DONE),
		.FOD_NOT_LOWER(FOD_NOT_LOWER), .FOD_VTH(FOD_VTH));

	// ****************************************
	// Helpers
	// ****************************************
	// Clock, 100 ns period
	initial begin
		SYS_CLK = 1'b0;
		forever #50 SYS_CLK = ~SYS_CLK;
	end

	// Hang guard
	always @(posedge SYS_CLK) begin
		cycles++;
		if (cycles == 10000) begin
			mismatches++;
			print_verdict();
		end
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	function automatic logic [7:0] ctd_ms(input logic [3:0] c);
		return 8'h46 + 8'(c) * 8'h02;
	endfunction : ctd_ms

	function automatic logic [7:0] exp_rd(input int i, input logic [7:0] w);
		return (w & REG_WMASK[i]) | (REG_RST[i] & ~REG_WMASK[i]);
	endfunction : exp_rd

	function automatic logic exp_nl(input int s1, input int s2, input int c);
		return (s2 + 2 * (c + 1)) >= s1;
	endfunction : exp_nl

	task automatic print_verdict();
		if (mismatches == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : print_verdict

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			$display("unexpected %s: expected %0h, seen %0h", what, exp, got);
			mismatches++;
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge SYS_CLK);
		#1;
	endtask : cyc

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge SYS_CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge SYS_CLK);
		WR <= 1'b0;
	endtask : wr

	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge SYS_CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge SYS_CLK);
		RD <= 1'b0;
		#1;
		chk($sformatf("reg %h", a), exp, RDATA);
	endtask : rdchk

	task automatic ovp(input logic [4:0] v, input int len);
		@(posedge SYS_CLK);
		OV_DET <= v;
		repeat (len) @(posedge SYS_CLK);
		OV_DET <= '0;
	endtask : ovp

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		int n;
		logic [3:0] w;
		RSTN = 1'b0;
		WR = 1'b0;
		RD = 1'b0;
		ADDR = '0;
		WDATA = '0;
		STD_STANDARD_OVERCURRENT_ENABLE = 1'b0;
		WDT_TIMEOUT = 1'b0;
		OT_DET = 1'b0;
		SINK_CONNECTED = 1'b0;
		ADC_DATA = '0;
		CUR_DET = '0;
		OV_DET = '0;
		repeat (2) @(posedge SYS_CLK);
		RSTN <= 1'b1;
		cyc(2);
		// Reset state
		chk("sw_on", 4'hF, SW_ON);
		chk("ctd", ctd_ms(4'h0), CTD_DELAY_MS);
		chk("fod", ctd_ms(4'h0) + 8'h14, FOD_DELAY_MS);
		chk("level", {7'h22, 7'h22, 2'h2, 7'h22, 2'h2, 1'b0}, CUR_LEVEL);
		chk("vth", {10'h070, 10'h070, 10'h01B}, FOD_VTH);
		for (int i = 0; i < NREG; i++)
			if (i != IX_OVSTS) rdchk(REG_ADDR[i], REG_RST[i]);
		rdchk(8'h3D, 8'h0F);
		// Random writes with read-back, then the outputs they drive
		for (int i = 0; i < NREG; i++) begin
			if (i == IX_CSTS || i == IX_OVSTS) continue;
			wv[i] = 8'(rnd());
			if (i == IX_FODD) wv[i][3:0] = wv[i][3:0] | 4'hC;
			wr(REG_ADDR[i], wv[i]);
			rdchk(REG_ADDR[i], exp_rd(i, wv[i]));
		end
		wr(8'h20, 8'hA5);
		rdchk(8'h20, 8'h00);
		cyc(2);
		chk("level", {wv[IX_OC1][6:0], wv[IX_OC2][6:0], wv[IX_OC3][1:0], wv[IX_RC1][6:0], wv[IX_RC3][1:0],
			wv[IX_VSEL][0]}, CUR_LEVEL);
		chk("ctd", ctd_ms(wv[IX_FODD][7:4]), CTD_DELAY_MS);
		chk("fod", ctd_ms(wv[IX_FODD][7:4]) + 8'(wv[IX_FODD][3:0]) * 8'h02, FOD_DELAY_MS);
		chk("vth", {wv[IX_TOL][1:0], wv[IX_VTH0L], wv[IX_VTH1H][1:0], wv[IX_VTH1L], wv[IX_VTH2H][1:0],
			wv[IX_VTH2L]}, FOD_VTH);
		chk("sw_on", wv[IX_SWEN][3:0], SW_ON);
		for (int i = 0; i < NREG; i++)
			if (REG_WMASK[i] != 8'h00) wr(REG_ADDR[i], REG_RST[i]);
		// Watchdog restore and overtemperature gating
		for (int k = 0; k < 4; k++) begin
			w = 4'(rnd());
			wr(8'h36, {4'h0, w});
			@(posedge SYS_CLK);
			WDT_TIMEOUT <= 1'b1;
			@(posedge SYS_CLK);
			WDT_TIMEOUT <= 1'b0;
			#1;
			chk("restore", w, PATH_RESTORE);
			wr(8'h37, {6'h00, k[1], k[0]});
			@(posedge SYS_CLK);
			OT_DET <= 1'b1;
			cyc(2);
			chk("ot", k[0], OT_PROTECT);
			chk("vconn", k[0] & k[1], VCONN_OFF);
			@(posedge SYS_CLK);
			OT_DET <= 1'b0;
		end
		// Current channels: immediate, short steps, long steps, fixed channels
		wr(8'h14, 8'h16);
		@(posedge SYS_CLK);
		STD_STANDARD_OVERCURRENT_ENABLE <= 1'b1;
		rdchk(8'h14, 8'h17);
		wr(8'h19, 8'h00);
		wr(8'h1A, 8'h02);
		wr(8'h1E, 8'h81);
		@(posedge SYS_CLK);
		CUR_DET <= 5'h10;
		cyc(2);
		chk("alert", 1, ALERT);
		rdchk(8'h15, 8'h01);
		@(posedge SYS_CLK);
		CUR_DET <= 5'h00;
		rdchk(8'h15, 8'h01);
		rdchk(8'h15, 8'h00);
		@(posedge SYS_CLK);
		CUR_DET <= 5'h08;
		cyc(190);
		chk("alert", 0, ALERT);
		cyc(215);
		chk("alert", 1, ALERT);
		@(posedge SYS_CLK);
		CUR_DET <= 5'h02;
		rdchk(8'h15, 8'h02);
		cyc(785);
		chk("alert", 0, ALERT);
		cyc(215);
		chk("alert", 1, ALERT);
		@(posedge SYS_CLK);
		CUR_DET <= 5'h05;
		cyc(3);
		rdchk(8'h15, 8'h54);
		@(posedge SYS_CLK);
		CUR_DET <= 5'h00;
		rdchk(8'h15, 8'h44);
		wr(8'h14, 8'h00);
		@(posedge SYS_CLK);
		STD_STANDARD_OVERCURRENT_ENABLE <= 1'b0;
		CUR_DET <= 5'h1F;
		cyc(5);
		chk("alert", 0, ALERT);
		rdchk(8'h14, 8'h00);
		@(posedge SYS_CLK);
		CUR_DET <= 5'h00;
		// Overvoltage cases from the table
		for (int k = 0; k < 6; k++) begin
			wr(8'h3C, o_ctl[k]);
			ovp(o_pin[k], o_len[k]);
			cyc(o_w1[k]);
			chk("sw_on", o_sw[k], SW_ON);
			chk("vconn", o_vc[k], VCONN_OFF);
			cyc(70);
			chk("sw_on", 4'hF, SW_ON);
			rdchk(8'h3D, o_flg[k]);
			rdchk(8'h3D, 8'h0F);
		end
		wr(8'h3C, 8'h00);
		// Foreign-object check at the tolerance boundary, then blocked by the sink enable
		wr(8'h56, 8'h10);
		wr(8'h54, 8'h80);
		for (int k = 0; k < 2; k++) begin
			@(posedge SYS_CLK);
			ADC_DATA <= 10'd100;
			SINK_CONNECTED <= 1'b1;
			cyc(2);
			chk("pullup", 1, FOD_PULLUP_ON);
			cyc(300);
			@(posedge SYS_CLK);
			ADC_DATA <= 10'(96 - k);
			n = 303;
			while (FOD_DONE !== 1'b1 && n < 1200) begin
				cyc(1);
				n++;
			end
			chk("done time", 1, (n >= 875) && (n <= 905));
			chk("not lower", exp_nl(100, 96 - k, 1), FOD_NOT_LOWER);
			@(posedge SYS_CLK);
			SINK_CONNECTED <= 1'b0;
			cyc(3);
			chk("pullup", 0, FOD_PULLUP_ON);
		end
		wr(8'h60, 8'h80);
		@(posedge SYS_CLK);
		SINK_CONNECTED <= 1'b1;
		cyc(3);
		chk("pullup", 0, FOD_PULLUP_ON);
		print_verdict();
	end
endmodule : vppr_regs_tb
